// [common/sfps_pkg.sv]
// shared constants of the serial flash command engine
package sfps_pkg;
  // ********************
  // geometry
  // ********************
  localparam int PAGE_BYTES = 264;
  localparam int PAGES = 4096;
  localparam int ARR_BYTES = PAGE_BYTES * PAGES;
  localparam logic [8:0] LAST_LOC = 9'h107;
  localparam logic [5:0] OP_BITS = 6'h08;
  localparam logic [5:0] HDR_BITS = 6'h20;
  localparam logic [5:0] WRAP_TOP = 6'h27;
  // ********************
  // opcodes
  // ********************
  localparam logic [7:0] OP_WR_B1 = 8'h84;
  localparam logic [7:0] OP_WR_B2 = 8'h87;
  localparam logic [7:0] OP_PE_B1 = 8'h83;
  localparam logic [7:0] OP_PE_B2 = 8'h86;
  localparam logic [7:0] OP_PN_B1 = 8'h88;
  localparam logic [7:0] OP_PN_B2 = 8'h89;
  localparam logic [7:0] OP_MP_B1 = 8'h82;
  localparam logic [7:0] OP_MP_B2 = 8'h85;
  localparam logic [7:0] OP_RW_B1 = 8'h58;
  localparam logic [7:0] OP_RW_B2 = 8'h59;
  localparam logic [7:0] OP_XF_B1 = 8'h53;
  localparam logic [7:0] OP_XF_B2 = 8'h55;
  localparam logic [7:0] OP_CM_B1 = 8'h60;
  localparam logic [7:0] OP_CM_B2 = 8'h61;
  localparam logic [7:0] OP_STAT = 8'h57;
  // ********************
  // device_state_word layout
  // ********************
  localparam int ST_RDY = 7;
  localparam int ST_CMP = 6;
  // arbitrary value, not a real density code
  localparam logic [2:0] DENSITY_CODE = 3'h5;
  localparam logic [2:0] ST_RSV = 3'h0;
  // ********************
  // timing
  // ********************
  localparam int REF_MHZ = 200;
  localparam int T_EP_US = 20000;
  localparam int T_P_US = 14000;
  localparam int T_XFR_US = 150;
  localparam int T_EP_CYC = T_EP_US * REF_MHZ;
  localparam int T_P_CYC = T_P_US * REF_MHZ;
  localparam int T_XFR_CYC = T_XFR_US * REF_MHZ;
  localparam logic [3:0] SCK_HALF = 4'ha;
endpackage

// [common/sfps_link_if.sv]
// serial link between host controller and flash device
interface sfps_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic rdy_oe;
  logic so_line;
  logic rdy_line;
  // pulled-up open lines
  assign so_line = so_oe ? so : 1'b1;
  assign rdy_line = ~rdy_oe;
  modport dev (input cs_n, input sck, input si, output so, output so_oe, output rdy_oe);
  modport host (output cs_n, output sck, output si, input so_line, input rdy_line);
endinterface

// [src/sfps_dev.sv]
// flash device end: serial command decode, buffers, array and status
module sfps_dev
  import sfps_pkg::*;
#(
  parameter int TEP_CYC = T_EP_CYC,
  parameter int TP_CYC = T_P_CYC,
  parameter int TXFR_CYC = T_XFR_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  sfps_link_if.dev link,
  output logic [7:0] device_state_out,
  output logic busy_out
);
  typedef enum logic [2:0] {C_IDLE, C_XFER, C_CMP, C_PROG, C_WAIT} sfps_core_t;

  // ********************
  // link clock domain: frame shifter
  // ********************
  logic [5:0] bit_cnt, next_bit_cnt;
  logic [31:0] shreg, next_shreg;
  logic [7:0] op, next_op;
  logic [23:0] addr, next_addr;
  logic [8:0] wr_idx, next_wr_idx;
  logic [8:0] wr_loc, next_wr_loc;
  logic [7:0] wr_byte, next_wr_byte;
  logic wr_sel, next_wr_sel;
  logic wr_tgl, next_wr_tgl;
  logic hdr_tgl, next_hdr_tgl;
  logic [1:0] st_s1, st_s2;
  logic so_bit, at7;
  logic [7:0] live_word;
  logic is_wr_op;
  logic busy, next_busy;
  logic cmp_flag, next_cmp_flag;

  assign is_wr_op = (op == OP_WR_B1) || (op == OP_WR_B2) || (op == OP_MP_B1) || (op == OP_MP_B2);

  always_comb begin
    next_bit_cnt = (bit_cnt == WRAP_TOP) ? HDR_BITS : bit_cnt + 6'h01;
    next_shreg = {shreg[30:0], link.si};
    next_op = op;
    next_addr = addr;
    next_wr_idx = wr_idx;
    next_wr_loc = wr_loc;
    next_wr_byte = wr_byte;
    next_wr_sel = wr_sel;
    next_wr_tgl = wr_tgl;
    next_hdr_tgl = hdr_tgl;
    if (bit_cnt == OP_BITS - 6'h01) begin
      next_op = next_shreg[7:0];
    end
    if (bit_cnt == HDR_BITS - 6'h01) begin
      next_addr = next_shreg[23:0];
      next_wr_idx = next_shreg[8:0];
      next_hdr_tgl = ~hdr_tgl;
    end
    if (bit_cnt >= HDR_BITS && bit_cnt[2:0] == 3'h7 && is_wr_op) begin
      next_wr_loc = wr_idx;
      next_wr_byte = next_shreg[7:0];
      next_wr_sel = (op == OP_WR_B2) || (op == OP_MP_B2);
      next_wr_tgl = ~wr_tgl;
      next_wr_idx = (wr_idx == LAST_LOC) ? 9'h000 : wr_idx + 9'h001;
    end
  end

  // bit counter ends with the frame itself
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt <= 6'h00;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end

  always_ff @(posedge link.sck or posedge rst_in) begin
    if (rst_in) begin
      shreg <= 32'h0000_0000;
      op <= 8'h00;
      addr <= 24'h00_0000;
      wr_idx <= 9'h000;
      wr_loc <= 9'h000;
      wr_byte <= 8'h00;
      wr_sel <= 1'b0;
      wr_tgl <= 1'b0;
      hdr_tgl <= 1'b0;
      st_s1 <= 2'h0;
      st_s2 <= 2'h0;
    end else begin
      shreg <= next_shreg;
      op <= next_op;
      addr <= next_addr;
      wr_idx <= next_wr_idx;
      wr_loc <= next_wr_loc;
      wr_byte <= next_wr_byte;
      wr_sel <= next_wr_sel;
      wr_tgl <= next_wr_tgl;
      hdr_tgl <= next_hdr_tgl;
      st_s1 <= {busy, cmp_flag};
      st_s2 <= st_s1;
    end
  end

  assign live_word = {~st_s2[1], st_s2[0], DENSITY_CODE, ST_RSV};

  // status bits change on the falling edge
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      so_bit <= 1'b1;
      at7 <= 1'b0;
    end else begin
      so_bit <= live_word[3'h7 - bit_cnt[2:0]];
      at7 <= (op == OP_STAT) && (bit_cnt >= OP_BITS) && (bit_cnt[2:0] == 3'h0);
    end
  end

  // ********************
  // core domain: crossings
  // ********************
  logic cs_s1, cs_s2, cs_s3;
  logic hdr_s1, hdr_s2;
  logic wr_s1, wr_s2, wr_s3;
  logic sob_s1, sob_s2, at7_s1, at7_s2;
  logic cs_rise, wr_fire;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {hdr_s1, hdr_s2} <= 2'h0;
      {wr_s1, wr_s2, wr_s3} <= 3'h0;
      {sob_s1, sob_s2, at7_s1, at7_s2} <= 4'h0;
    end else begin
      {cs_s1, cs_s2, cs_s3} <= {link.cs_n, cs_s1, cs_s2};
      {hdr_s1, hdr_s2} <= {hdr_tgl, hdr_s1};
      {wr_s1, wr_s2, wr_s3} <= {wr_tgl, wr_s1, wr_s2};
      {sob_s1, sob_s2, at7_s1, at7_s2} <= {so_bit, sob_s1, at7, at7_s1};
    end
  end

  assign cs_rise = cs_s2 && !cs_s3;
  assign wr_fire = wr_s2 ^ wr_s3;

  // ********************
  // core domain: array sequencer
  // ********************
  sfps_core_t state, next_state;
  logic mism, next_mism;
  logic is_cmp, next_is_cmp;
  logic then_prog, next_then_prog;
  logic erase, next_erase;
  logic sel, next_sel;
  logic hdr_seen, next_hdr_seen;
  logic [8:0] idx, next_idx;
  logic [11:0] page, next_page;
  logic [22:0] timer, next_timer;
  logic [22:0] wait_len, next_wait_len;
  logic so_q, next_so_q;
  logic so_oe_q, next_so_oe_q;
  logic [7:0] buf_mem [0:1][0:PAGE_BYTES-1];
  logic [7:0] arr_mem [0:ARR_BYTES-1];
  logic [20:0] arr_addr;
  logic last;

  assign arr_addr = 21'(page) * 21'(PAGE_BYTES) + 21'(idx);
  assign last = (idx == LAST_LOC);

  always_comb begin
    next_state = state;
    next_busy = busy;
    next_cmp_flag = cmp_flag;
    next_mism = mism;
    next_is_cmp = is_cmp;
    next_then_prog = then_prog;
    next_erase = erase;
    next_sel = sel;
    next_hdr_seen = hdr_seen;
    next_idx = idx;
    next_page = page;
    next_timer = timer;
    next_wait_len = wait_len;
    next_so_q = at7_s2 ? ~busy : sob_s2;
    next_so_oe_q = !cs_s2;
    unique case (state)
      C_IDLE: begin
        if (cs_rise && (hdr_s2 != hdr_seen)) begin
          next_hdr_seen = hdr_s2;
          next_page = addr[20:9];
          next_idx = 9'h000;
          next_mism = 1'b0;
          next_is_cmp = 1'b0;
          next_then_prog = 1'b0;
          next_erase = 1'b1;
          next_sel = op[0] ^ op[2] ^ (op == OP_WR_B2); // placeholder select; each opcode branch below sets its own buffer
          next_busy = 1'b1;
          case (op)
            OP_PE_B1, OP_PE_B2, OP_MP_B1, OP_MP_B2: begin
              next_sel = (op == OP_PE_B2) || (op == OP_MP_B2);
              next_state = C_PROG;
              next_wait_len = 23'(TEP_CYC);
            end
            OP_PN_B1, OP_PN_B2: begin
              next_sel = (op == OP_PN_B2);
              next_erase = 1'b0;
              next_state = C_PROG;
              next_wait_len = 23'(TP_CYC);
            end
            OP_RW_B1, OP_RW_B2: begin
              next_sel = (op == OP_RW_B2);
              next_then_prog = 1'b1;
              next_state = C_XFER;
              next_wait_len = 23'(TEP_CYC);
            end
            OP_XF_B1, OP_XF_B2: begin
              next_sel = (op == OP_XF_B2);
              next_state = C_XFER;
              next_wait_len = 23'(TXFR_CYC);
            end
            OP_CM_B1, OP_CM_B2: begin
              next_sel = (op == OP_CM_B2);
              next_is_cmp = 1'b1;
              next_state = C_CMP;
              next_wait_len = 23'(TXFR_CYC);
            end
            default: begin
              next_busy = 1'b0;
            end
          endcase
        end else if (cs_rise) begin
          next_hdr_seen = hdr_s2;
        end
      end
      C_XFER: begin
        next_idx = last ? 9'h000 : idx + 9'h001;
        if (last) begin
          next_state = then_prog ? C_PROG : C_WAIT;
        end
      end
      C_CMP: begin
        if (buf_mem[sel][idx] != arr_mem[arr_addr]) begin
          next_mism = 1'b1;
        end
        next_idx = last ? 9'h000 : idx + 9'h001;
        if (last) begin
          next_state = C_WAIT;
        end
      end
      C_PROG: begin
        next_idx = last ? 9'h000 : idx + 9'h001;
        if (last) begin
          next_state = C_WAIT;
          next_timer = 23'h00_0000;
        end
      end
      C_WAIT: begin
        next_timer = timer + 23'h00_0001;
        if (timer >= wait_len - 23'h00_0001) begin
          next_state = C_IDLE;
          next_busy = 1'b0;
          if (is_cmp) begin
            next_cmp_flag = mism;
          end
        end
      end
    endcase
    // frames taken while busy still consume their header
    if (cs_rise && state != C_IDLE) begin
      next_hdr_seen = hdr_s2;
    end
    if (state == C_XFER && last && !then_prog) begin
      next_timer = 23'h00_0000;
    end
    if (state == C_CMP && last) begin
      next_timer = 23'h00_0000;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state <= C_IDLE;
      busy <= 1'b0;
      cmp_flag <= 1'b0;
      mism <= 1'b0;
      is_cmp <= 1'b0;
      then_prog <= 1'b0;
      erase <= 1'b1;
      sel <= 1'b0;
      hdr_seen <= 1'b0;
      idx <= 9'h000;
      page <= 12'h000;
      timer <= 23'h00_0000;
      wait_len <= 23'h00_0001;
      so_q <= 1'b1;
      so_oe_q <= 1'b0;
      device_state_out <= {1'b1, 1'b0, DENSITY_CODE, ST_RSV};
    end else begin
      state <= next_state;
      busy <= next_busy;
      cmp_flag <= next_cmp_flag;
      mism <= next_mism;
      is_cmp <= next_is_cmp;
      then_prog <= next_then_prog;
      erase <= next_erase;
      sel <= next_sel;
      hdr_seen <= next_hdr_seen;
      idx <= next_idx;
      page <= next_page;
      timer <= next_timer;
      wait_len <= next_wait_len;
      so_q <= next_so_q;
      so_oe_q <= next_so_oe_q;
      device_state_out <= {~next_busy, next_cmp_flag, DENSITY_CODE, ST_RSV};
    end
  end

  // ********************
  // storage
  // ********************
  always_ff @(posedge ref_clk_in) begin
    if (wr_fire && wr_loc <= LAST_LOC) begin
      buf_mem[wr_sel][wr_loc] <= wr_byte;
    end
    if (state == C_XFER) begin
      buf_mem[sel][idx] <= arr_mem[arr_addr];
    end
    if (state == C_PROG) begin
      arr_mem[arr_addr] <= erase ? buf_mem[sel][idx] : (arr_mem[arr_addr] & buf_mem[sel][idx]);
    end
  end

  assign link.so = so_q;
  assign link.so_oe = so_oe_q;
  assign link.rdy_oe = busy;
  assign busy_out = busy;
endmodule

// [src/sfps_host.sv]
// host end: frames commands on the serial link from a request port
module sfps_host
  import sfps_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  sfps_link_if.host link,
  input wire logic req_valid_in,
  input wire logic [7:0] req_op_in,
  input wire logic [23:0] req_addr_in,
  input wire logic [8:0] req_bytes_in,
  input wire logic [7:0] data_in,
  output logic req_ready_out,
  output logic data_take_out,
  output logic [7:0] status_out,
  output logic status_valid_out,
  output logic dev_ready_out
);
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} sfps_host_t;

  // ********************
  // pin synchronisers
  // ********************
  logic so_s1, so_s2, rdy_s1, rdy_s2;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      {so_s1, so_s2, rdy_s1, rdy_s2} <= 4'hf;
    end else begin
      {so_s1, so_s2, rdy_s1, rdy_s2} <= {link.so_line, so_s1, link.rdy_line, rdy_s1};
    end
  end

  // ********************
  // framer
  // ********************
  sfps_host_t state, next_state;
  logic cs_n, next_cs_n;
  logic sck, next_sck;
  logic si, next_si;
  logic [3:0] half, next_half;
  logic [31:0] tx, next_tx;
  logic [7:0] rx, next_rx;
  logic [12:0] bit_no, next_bit_no;
  logic [12:0] total, next_total;
  logic [12:0] hdr, next_hdr;
  logic stat_op, next_stat_op;
  logic take, next_take;
  logic [7:0] stat, next_stat;
  logic stat_v, next_stat_v;
  logic [12:0] nb;

  assign nb = bit_no + 13'h0001;

  always_comb begin
    next_state = state;
    next_cs_n = cs_n;
    next_sck = sck;
    next_si = si;
    next_half = (half == SCK_HALF - 4'h1) ? 4'h0 : half + 4'h1;
    next_tx = tx;
    next_rx = rx;
    next_bit_no = bit_no;
    next_total = total;
    next_hdr = hdr;
    next_stat_op = stat_op;
    next_take = 1'b0;
    next_stat = stat;
    next_stat_v = 1'b0;
    unique case (state)
      H_IDLE: begin
        next_half = 4'h0;
        if (req_valid_in) begin
          next_stat_op = (req_op_in == OP_STAT);
          next_hdr = (req_op_in == OP_STAT) ? 13'(OP_BITS) : 13'(HDR_BITS);
          next_total = ((req_op_in == OP_STAT) ? 13'(OP_BITS) : 13'(HDR_BITS))
                       + {1'b0, req_bytes_in, 3'h0};
          next_tx = {req_op_in, req_addr_in};
          next_si = req_op_in[7];
          next_cs_n = 1'b0;
          next_bit_no = 13'h0000;
          next_state = H_LOW;
        end
      end
      H_LOW: begin
        if (half == SCK_HALF - 4'h1) begin
          next_sck = 1'b1;
          next_rx = {rx[6:0], so_s2};
          if (stat_op && bit_no >= 13'(OP_BITS) && bit_no[2:0] == 3'h7) begin
            next_stat = {rx[6:0], so_s2};
            next_stat_v = 1'b1;
          end
          next_state = H_HIGH;
        end
      end
      H_HIGH: begin
        if (half == SCK_HALF - 4'h1) begin
          next_sck = 1'b0;
          next_bit_no = nb;
          next_tx = {tx[30:0], 1'b0};
          if (nb >= hdr && nb[2:0] == 3'h0 && !stat_op) begin
            next_tx = {data_in, 24'h00_0000};
            next_take = (nb != total);
          end
          next_si = next_tx[31];
          next_state = (nb == total) ? H_GAP : H_LOW;
        end
      end
      H_GAP: begin
        next_cs_n = 1'b1;
        if (half == SCK_HALF - 4'h1) begin
          next_state = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state <= H_IDLE;
      cs_n <= 1'b1;
      sck <= 1'b0;
      si <= 1'b0;
      half <= 4'h0;
      tx <= 32'h0000_0000;
      rx <= 8'h00;
      bit_no <= 13'h0000;
      total <= 13'h0000;
      hdr <= 13'h0000;
      stat_op <= 1'b0;
      take <= 1'b0;
      stat <= 8'h00;
      stat_v <= 1'b0;
      req_ready_out <= 1'b0;
      dev_ready_out <= 1'b1;
    end else begin
      state <= next_state;
      cs_n <= next_cs_n;
      sck <= next_sck;
      si <= next_si;
      half <= next_half;
      tx <= next_tx;
      rx <= next_rx;
      bit_no <= next_bit_no;
      total <= next_total;
      hdr <= next_hdr;
      stat_op <= next_stat_op;
      take <= next_take;
      stat <= next_stat;
      stat_v <= next_stat_v;
      req_ready_out <= (next_state == H_IDLE);
      dev_ready_out <= rdy_s2;
    end
  end

  assign link.cs_n = cs_n;
  assign link.sck = sck;
  assign link.si = si;
  assign data_take_out = take;
  assign status_out = stat;
  assign status_valid_out = stat_v;
endmodule

// [tb/sfps_props.sv]
// link assertions for the host and flash device pair
module sfps_props #(
  parameter int WAIT_CYC = 20
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_oe,
  input wire logic rdy_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOOP_CYC = 264;
  logic sck_d;
  logic [15:0] rises;
  logic [15:0] busy_len;
  logic [3:0] cs_age;
  // ****************
  // helper counters
  // ****************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sck_d <= 1'b0;
      rises <= 16'h0000;
      busy_len <= 16'h0000;
      cs_age <= 4'hf;
    end else begin
      sck_d <= sck;
      rises <= cs_n ? 16'h0000 : rises + 16'(sck & ~sck_d);
      busy_len <= rdy_oe ? busy_len + 16'h0001 : 16'h0000;
      cs_age <= !cs_n ? 4'h0 : ((cs_age == 4'hf) ? cs_age : cs_age + 4'h1);
    end
  end
  // ****************
  // properties
  // ****************
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence sck_high_s;
    sck[*8] ##1 sck[*2] ##1 !sck;
  endsequence
  sequence cs_gap_s;
    cs_n[*8] ##1 cs_n[*2];
  endsequence
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock active outside a frame");
  half_period_a: assert property ($rose(sck) |-> sck_high_s)
    else $error("serial clock high phase not ten cycles");
  si_steady_a: assert property ($rose(sck) |-> $stable(si))
    else $error("serial input moved at clock rise");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_gap_s)
    else $error("select high time too short");
  whole_bytes_a: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0 && rises >= 16'h0008)
    else $error("frame not a whole number of bytes");
  so_release_a: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
    else $error("serial output not released after frame");
  so_drive_a: assert property ($rose(so_oe) |-> !cs_n)
    else $error("serial output driven outside a frame");
  busy_start_a: assert property ($rose(rdy_oe) |-> cs_n && cs_age <= 4'h8)
    else $error("busy began away from select rise");
  busy_len_a: assert property ($fell(rdy_oe) |->
    busy_len >= LOOP_CYC + WAIT_CYC - 2 && busy_len <= 2 * LOOP_CYC + WAIT_CYC + 8)
    else $error("busy length out of range");
endmodule

// [tb/tb_top.sv]
// self-checking bench for the host and flash device pair
module tb_top
  import sfps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAIT = 1000;
  localparam logic [7:0] IDLE = {1'b1, 1'b0, DENSITY_CODE, ST_RSV};
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid = 1'b0;
  logic [7:0] req_op = 8'h00;
  logic [23:0] req_addr = 24'h000000;
  logic [8:0] req_bytes = 9'h000;
  logic [7:0] data_byte = 8'h00;
  logic req_ready, data_take, stat_valid, dev_ready, busy, sck_prev;
  logic [7:0] stat_byte, state, wire_op;
  logic [7:0] stat_q[$];
  int wire_bits = 0;
  int mismatches = 0;
  int checks_done = 0;
  int takes = 0;
  always #2.5 ref_clk_in = ~ref_clk_in;
  sfps_link_if sfps_link_if_inst ();
  sfps_dev #(.TEP_CYC(WAIT), .TP_CYC(WAIT), .TXFR_CYC(WAIT)) sfps_dev_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(sfps_link_if_inst),
    .device_state_out(state), .busy_out(busy));
  sfps_host sfps_host_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(sfps_link_if_inst),
    .req_valid_in(req_valid), .req_op_in(req_op), .req_addr_in(req_addr),
    .req_bytes_in(req_bytes), .data_in(data_byte), .req_ready_out(req_ready),
    .data_take_out(data_take), .status_out(stat_byte), .status_valid_out(stat_valid),
    .dev_ready_out(dev_ready));
  sfps_props #(.WAIT_CYC(WAIT)) sfps_props_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .cs_n(sfps_link_if_inst.cs_n), .sck(sfps_link_if_inst.sck), .si(sfps_link_if_inst.si),
    .so_oe(sfps_link_if_inst.so_oe), .rdy_oe(sfps_link_if_inst.rdy_oe));
  // ****************
  // link monitor
  // ****************
  always @(posedge ref_clk_in) begin
    sck_prev <= sfps_link_if_inst.sck;
    if (stat_valid === 1'b1) stat_q.push_back(stat_byte);
    if (data_take === 1'b1) takes++;
    if (sfps_link_if_inst.cs_n !== 1'b0) begin
      wire_bits = 0;
    end else if (sfps_link_if_inst.sck && !sck_prev && wire_bits < 8) begin
      wire_op = {wire_op[6:0], sfps_link_if_inst.si};
      wire_bits++;
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic hang(string what);
    $display("Error %s expected done seen timeout", what);
    mismatches++;
    report_and_stop();
  endtask
  function automatic logic [23:0] pa(logic [11:0] pg, logic [8:0] idx);
    return {3'h0, pg, idx};
  endfunction
  task automatic do_req(logic [7:0] op, logic [23:0] addr, logic [8:0] nb, logic [7:0] dat);
    int n;
    @(negedge ref_clk_in);
    req_valid = 1'b1;
    req_op = op;
    req_addr = addr;
    req_bytes = nb;
    data_byte = dat;
    takes = 0;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (n >= 100) hang("request");
    @(negedge ref_clk_in);
    req_valid = 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (req_ready !== 1'b1 && n < 50000);
    if (n >= 50000) hang("frame");
    chk("wire opcode", op, wire_op);
    chk("data takes", (op == OP_STAT) ? 8'h00 : nb[7:0], 8'(takes));
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (n >= 4000) hang("busy");
  endtask
  task automatic arr(logic [7:0] op, logic [23:0] addr, logic [8:0] nb, logic [7:0] dat,
    bit hold);
    do_req(op, addr, nb, dat);
    chk("busy", 8'h01, {7'h00, busy});
    chk("ready line", 8'h00, {7'h00, sfps_link_if_inst.rdy_line});
    chk("ready pin", 8'h00, {7'h00, dev_ready});
    if (!hold) wait_idle();
  endtask
  task automatic cmp(logic [7:0] op, logic [23:0] addr, logic bitv);
    arr(op, addr, 9'h000, 8'h00, 1'b0);
    chk("state word", {1'b1, bitv, DENSITY_CODE, ST_RSV}, state);
  endtask
  task automatic status(logic [8:0] nb, logic [7:0] exp);
    stat_q.delete();
    do_req(OP_STAT, 24'h000000, nb, 8'h00);
    chk("status count", nb[7:0], 8'(stat_q.size()));
    foreach (stat_q[i]) chk("status byte", exp, stat_q[i]);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (16) @(negedge ref_clk_in);
    rst_in = 1'b0;
    @(negedge ref_clk_in);
    chk("state word", IDLE, state);
    status(9'h002, IDLE);
    arr(OP_MP_B1, pa(12'h001, 9'h000), 9'h108, 8'hff, 1'b0);
    cmp(OP_CM_B1, pa(12'h001, 9'h000), 1'b0);
    do_req(OP_WR_B1, {15'h0000, LAST_LOC}, 9'h002, 8'h0f);
    cmp(OP_CM_B1, pa(12'h001, 9'h000), 1'b1);
    do_req(8'h00, pa(12'h001, 9'h000), 9'h000, 8'h00);
    chk("busy", 8'h00, {7'h00, busy});
    chk("state word", IDLE | 8'h40, state);
    arr(OP_RW_B1, pa(12'h001, 9'h000), 9'h000, 8'h00, 1'b1);
    status(9'h001, {1'b0, 1'b1, DENSITY_CODE, ST_RSV});
    wait_idle();
    cmp(OP_CM_B1, pa(12'h001, 9'h000), 1'b0);
    arr(OP_RW_B2, pa(12'h001, 9'h000), 9'h000, 8'h00, 1'b0);
    arr(OP_PE_B2, pa(12'h002, 9'h000), 9'h000, 8'h00, 1'b1);
    do_req(OP_WR_B1, pa(12'h000, 9'h005), 9'h001, 8'h3c);
    chk("busy", 8'h01, {7'h00, busy});
    wait_idle();
    cmp(OP_CM_B2, pa(12'h002, 9'h000), 1'b0);
    cmp(OP_CM_B1, pa(12'h002, 9'h000), 1'b1);
    arr(OP_PN_B1, pa(12'h002, 9'h000), 9'h000, 8'h00, 1'b0);
    cmp(OP_CM_B1, pa(12'h002, 9'h000), 1'b0);
    cmp(OP_CM_B2, pa(12'h002, 9'h000), 1'b1);
    arr(OP_PE_B2, pa(12'h002, 9'h000), 9'h000, 8'h00, 1'b0);
    cmp(OP_CM_B2, pa(12'h002, 9'h000), 1'b0);
    arr(OP_PN_B2, pa(12'h002, 9'h000), 9'h000, 8'h00, 1'b0);
    cmp(OP_CM_B2, pa(12'h002, 9'h000), 1'b0);
    arr(OP_MP_B2, pa(12'h004, 9'h005), 9'h001, 8'h3c, 1'b1);
    do_req(OP_WR_B1, pa(12'h000, 9'h000), 9'h001, 8'h00);
    wait_idle();
    cmp(OP_CM_B2, pa(12'h004, 9'h000), 1'b0);
    cmp(OP_CM_B1, pa(12'h004, 9'h000), 1'b1);
    status(9'h001, IDLE | 8'h40);
    arr(OP_XF_B2, pa(12'h001, 9'h000), 9'h000, 8'h00, 1'b0);
    cmp(OP_CM_B2, pa(12'h001, 9'h000), 1'b0);
    status(9'h002, IDLE);
    report_and_stop();
  end
endmodule
